// >>> logic/pcm_slot_pkg.sv
// package: command codes, field layouts and reset values of the slot
// and configuration command registers; shared by all design files
package pcm_slot_pkg;

  localparam int NUM_CHANNELS = 4;

  // command bytes (bit 0 is the read flag on read/write pairs)
  localparam logic [7:0] CMD_HW_RESET = 8'h04;
  localparam logic [7:0] CMD_SW_RESET = 8'h02;
  localparam logic [7:0] CMD_TX_SLOT_WR = 8'h40;
  localparam logic [7:0] CMD_TX_SLOT_RD = 8'h41;
  localparam logic [7:0] CMD_RX_SLOT_WR = 8'h42;
  localparam logic [7:0] CMD_RX_SLOT_RD = 8'h43;
  localparam logic [7:0] CMD_CLK_SLOT_WR = 8'h44;
  localparam logic [7:0] CMD_CLK_SLOT_RD = 8'h45;
  localparam logic [7:0] CMD_CHIP_CFG_WR = 8'h46;
  localparam logic [7:0] CMD_CHIP_CFG_RD = 8'h47;
  localparam logic [7:0] CMD_CHAN_EN_WR = 8'h4a;
  localparam logic [7:0] CMD_CHAN_EN_RD = 8'h4b;
  localparam logic [7:0] CMD_RT_DATA_RD = 8'h4d;
  localparam logic [7:0] CMD_RT_DATA_RD_CLR = 8'h4f;
  localparam logic [7:0] CMD_IRQ_MASK_WR = 8'h6c;
  localparam logic [7:0] CMD_IRQ_MASK_RD = 8'h6d;

  // serial framing: bits per byte, and the count that means hardware reset
  localparam logic [4:0] BITS_PER_BYTE = 5'h08;
  localparam logic [4:0] BITS_HW_RESET = 5'h10;

  // reset values
  localparam logic [7:0] TX_SLOT_RESET_CH1 = 8'h00;
  localparam logic [7:0] CLK_SLOT_RESET = 8'h00;
  localparam logic [7:0] CHIP_CFG_RESET = 8'h9a;
  localparam logic [7:0] CHAN_EN_RESET = 8'h0f;
  localparam logic [7:0] IRQ_MASK_RESET = 8'hff;

  // master clock frequency field: low pair picks base, high pair the multiple
  localparam logic [1:0] FREQ_BASE_RESERVED = 2'h3;
  localparam logic [1:0] FREQ_MULT_RESERVED = 2'h3;

  // chopper divider terminal counts (divide by 8 or by 7)
  localparam logic [2:0] CHOP_LAST_DIV8 = 3'h7;
  localparam logic [2:0] CHOP_LAST_DIV7 = 3'h6;

  typedef struct packed {
    logic hwySel;
    logic [6:0] slot;
  } slot_cfg_type;

  typedef struct packed {
    logic txBoth;
    logic txLaunchRise;
    logic [2:0] rxBitOffset;
    logic [2:0] txBitOffset;
  } clk_slot_type;

  typedef struct packed {
    logic irqOpenDrain;
    logic chopperDiv7;
    logic pcmSignalingEn;
    logic masterClkFromPcm;
    logic [1:0] freqMult;
    logic [1:0] freqBase;
  } chip_cfg_type;

  typedef struct packed {
    logic rsvd;
    logic robbedBitEn;
    logic idleOutHiZ;
    logic legacyPowerSave;
    logic [3:0] channelCmdEn;
  } chan_en_type;

  typedef enum logic [1:0] {
    WAIT_CMD,
    WAIT_WDATA,
    SEND_RDATA
  } mpi_state_type;

endpackage

// >>> logic/chan_slot_regs.sv
// one channel's transmit and receive time slot registers
// assumes write strobes are already gated by the channel's command enable
`timescale 1ns/1ps
module chan_slot_regs
  import pcm_slot_pkg::*;
#(
  parameter logic [7:0] SLOT_RESET = 8'h00
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hwReset,
  input wire logic txWrite,
  input wire logic rxWrite,
  input wire logic [7:0] wrData,
  output slot_cfg_type txCfg,
  output slot_cfg_type rxCfg
);

  slot_cfg_type txCfg_reg;
  slot_cfg_type rxCfg_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txCfg_reg <= slot_cfg_type'(SLOT_RESET);
    end else if (hwReset) begin
      txCfg_reg <= slot_cfg_type'(SLOT_RESET);
    end else if (txWrite) begin
      txCfg_reg <= slot_cfg_type'(wrData);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxCfg_reg <= slot_cfg_type'(SLOT_RESET);
    end else if (hwReset) begin
      rxCfg_reg <= slot_cfg_type'(SLOT_RESET);
    end else if (rxWrite) begin
      rxCfg_reg <= slot_cfg_type'(wrData);
    end
  end

  assign txCfg = txCfg_reg;
  assign rxCfg = rxCfg_reg;

endmodule

// >>> logic/pcm_slot_config.sv
// slot, clock-slot, chip configuration and channel enable command registers
// of a four-channel voice codec behind its byte-serial command port.
// assumes dclk, csN and dioIn are already synchronous to clock.
//
// What this block does
// - 40h writes, 41h reads transmit highway and slot
// - highway select 0 sends on A, 1 on B
// - transmit slot resets to channel number minus one
// - 42h writes, 43h reads receive highway and slot
// - receive highway select 0 takes A, 1 B
// - transmit-both bit drives both highways
// - launch edge bit: 0 falling, 1 rising
// - three-bit receive and transmit bit offsets, reset zero
// - global timing ignored when no channel enabled
// - interrupt style: 0 push-pull, 1 open drain
// - chopper divides 2048 kHz by 8 or 7
// - signaling bit enables highway signaling
// - clock source bit picks pin or PCM clock
// - frequency field: base and multiple, reserved codes
// - chip configuration resets to 9Ah
// - chip configuration ignores channel enables
// - per-channel command enables, reset 0Fh
// - robbed-bit active only with mu-law
// - idle output mode: resistor or high impedance
// - 4Dh reads inputs, 4Fh also clears interrupt
// - channel n inputs at bits 2n-2, 2n-1
// - real-time reads ignore channel enables
// - masked input changes never raise interrupt
// - software reset keeps slots and highways
`timescale 1ns/1ps
module pcm_slot_config
  import pcm_slot_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic dclk,
  input wire logic csN,
  input wire logic dioIn,
  output logic dioOut,
  output logic dioOe,
  input wire logic [7:0] rtInputs,
  input wire logic muLawSel,
  input wire logic e1MuxReq,
  input wire logic refClk2048,
  output logic irqOut,
  output logic irqOe,
  output slot_cfg_type [CHANNELS-1:0] txCfg,
  output slot_cfg_type [CHANNELS-1:0] rxCfg,
  output logic [CHANNELS-1:0] txOnHwyA,
  output logic [CHANNELS-1:0] txOnHwyB,
  output logic [CHANNELS-1:0] rxFromHwyB,
  output clk_slot_type clkSlot,
  output chip_cfg_type chipCfg,
  output chan_en_type chanEn,
  output logic robbedBitActive,
  output logic e1MuxAllowed,
  output logic masterFreqReserved,
  output logic chopperTick,
  output logic hwResetEvent
);

  // serial port sampling
  logic dclkPrev_reg;
  logic csPrev_reg;
  logic dclkRise;
  logic dclkFall;
  logic csEnd;

  assign dclkRise = dclk && !dclkPrev_reg;
  assign dclkFall = !dclk && dclkPrev_reg;
  assign csEnd = csN && !csPrev_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dclkPrev_reg <= 1'b1;
      csPrev_reg <= 1'b1;
    end else begin
      dclkPrev_reg <= dclk;
      csPrev_reg <= csN;
    end
  end

  // bit count within one chip-select low period, saturating at the reset count
  logic [4:0] bitCnt_reg;
  logic [7:0] shiftIn_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bitCnt_reg <= 5'h00;
    end else if (csN) begin
      bitCnt_reg <= 5'h00;
    end else if (dclkRise && bitCnt_reg != BITS_HW_RESET) begin
      bitCnt_reg <= bitCnt_reg + 5'h01;
    end
  end

  // keeps the last eight bits, so a nine-to-fifteen bit period uses its tail
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shiftIn_reg <= 8'h00;
    end else if (!csN && dclkRise) begin
      shiftIn_reg <= {shiftIn_reg[6:0], dioIn};
    end
  end

  logic byteDone;
  logic longFrame;

  assign longFrame = csEnd && bitCnt_reg == BITS_HW_RESET;
  assign byteDone = csEnd && bitCnt_reg >= BITS_PER_BYTE && !longFrame;

  // command sequencing
  mpi_state_type state_reg;
  mpi_state_type state_next;
  logic [7:0] pendCmd_reg;
  logic [7:0] readData;
  logic readAllowed;
  logic hwReset;
  logic [7:0] irqMask_reg;
  logic irqPend_reg;

  clk_slot_type clkSlot_reg;
  chip_cfg_type chipCfg_reg;
  chan_en_type chanEn_reg;
  logic [7:0] rtData_reg;

  logic anyEnabled;
  logic [1:0] firstEn;

  assign anyEnabled = |chanEn_reg.channelCmdEn;

  // reads of channel registers report the lowest enabled channel
  always_comb begin
    firstEn = 2'd0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (chanEn_reg.channelCmdEn[i]) begin
        firstEn = 2'(i);
      end
    end
  end

  assign hwReset = longFrame || (byteDone && state_reg == WAIT_CMD && shiftIn_reg == CMD_HW_RESET);

  always_comb begin
    readAllowed = 1'b0;
    readData = 8'h00;
    case (shiftIn_reg)
      CMD_TX_SLOT_RD: begin
        readAllowed = anyEnabled;
        readData = txCfg[firstEn];
      end
      CMD_RX_SLOT_RD: begin
        readAllowed = anyEnabled;
        readData = rxCfg[firstEn];
      end
      CMD_CLK_SLOT_RD: begin
        readAllowed = anyEnabled;
        readData = clkSlot_reg;
      end
      CMD_CHIP_CFG_RD: begin
        readAllowed = 1'b1;
        readData = chipCfg_reg;
      end
      CMD_CHAN_EN_RD: begin
        readAllowed = 1'b1;
        readData = chanEn_reg;
      end
      CMD_RT_DATA_RD, CMD_RT_DATA_RD_CLR: begin
        readAllowed = 1'b1;
        readData = rtData_reg;
      end
      CMD_IRQ_MASK_RD: begin
        readAllowed = 1'b1;
        readData = irqMask_reg;
      end
      default: begin
        readAllowed = 1'b0;
        readData = 8'h00;
      end
    endcase
  end

  logic isWriteCmd;

  assign isWriteCmd = shiftIn_reg == CMD_TX_SLOT_WR || shiftIn_reg == CMD_RX_SLOT_WR
    || shiftIn_reg == CMD_CLK_SLOT_WR || shiftIn_reg == CMD_CHIP_CFG_WR
    || shiftIn_reg == CMD_CHAN_EN_WR || shiftIn_reg == CMD_IRQ_MASK_WR;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      WAIT_CMD: begin
        if (byteDone && isWriteCmd) begin
          state_next = WAIT_WDATA;
        end else if (byteDone && readAllowed) begin
          state_next = SEND_RDATA;
        end
      end
      WAIT_WDATA: begin
        if (byteDone) begin
          state_next = WAIT_CMD;
        end
      end
      SEND_RDATA: begin
        if (byteDone) begin
          state_next = WAIT_CMD;
        end
      end
      default: begin
        state_next = WAIT_CMD;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= WAIT_CMD;
    end else if (hwReset) begin
      state_reg <= WAIT_CMD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pendCmd_reg <= 8'h00;
    end else if (byteDone && state_reg == WAIT_CMD) begin
      pendCmd_reg <= shiftIn_reg;
    end
  end

  // write strobes, applied on the data byte's chip-select release
  logic wrByte;
  logic wrTx;
  logic wrRx;

  assign wrByte = byteDone && state_reg == WAIT_WDATA;
  assign wrTx = wrByte && pendCmd_reg == CMD_TX_SLOT_WR;
  assign wrRx = wrByte && pendCmd_reg == CMD_RX_SLOT_WR;

  // software reset touches none of these registers, so it needs no path here
  genvar g;
  for (g = 0; g < CHANNELS; g++) begin : gen_chan
    chan_slot_regs #(
      .SLOT_RESET(TX_SLOT_RESET_CH1 + 8'(g))
    ) u_slots (
      .clock(clock),
      .nrst(nrst),
      .hwReset(hwReset),
      .txWrite(wrTx && chanEn_reg.channelCmdEn[g]),
      .rxWrite(wrRx && chanEn_reg.channelCmdEn[g]),
      .wrData(shiftIn_reg),
      .txCfg(txCfg[g]),
      .rxCfg(rxCfg[g])
    );
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clkSlot_reg <= clk_slot_type'(CLK_SLOT_RESET);
    end else if (hwReset) begin
      clkSlot_reg <= clk_slot_type'(CLK_SLOT_RESET);
    end else if (wrByte && pendCmd_reg == CMD_CLK_SLOT_WR && anyEnabled) begin
      clkSlot_reg <= clk_slot_type'(shiftIn_reg);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      chipCfg_reg <= chip_cfg_type'(CHIP_CFG_RESET);
    end else if (hwReset) begin
      chipCfg_reg <= chip_cfg_type'(CHIP_CFG_RESET);
    end else if (wrByte && pendCmd_reg == CMD_CHIP_CFG_WR) begin
      chipCfg_reg <= chip_cfg_type'(shiftIn_reg);
    end
  end

  // reserved and legacy bits are stored as written; the host must not count on them
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      chanEn_reg <= chan_en_type'(CHAN_EN_RESET);
    end else if (hwReset) begin
      chanEn_reg <= chan_en_type'(CHAN_EN_RESET);
    end else if (wrByte && pendCmd_reg == CMD_CHAN_EN_WR) begin
      chanEn_reg <= chan_en_type'(shiftIn_reg);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqMask_reg <= IRQ_MASK_RESET;
    end else if (hwReset) begin
      irqMask_reg <= IRQ_MASK_RESET;
    end else if (wrByte && pendCmd_reg == CMD_IRQ_MASK_WR) begin
      irqMask_reg <= shiftIn_reg;
    end
  end

  // read data out: first bit valid once chip select drops, next on each falling dclk after the first
  logic [7:0] shiftOut_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shiftOut_reg <= 8'h00;
    end else if (byteDone && state_reg == WAIT_CMD && readAllowed) begin
      shiftOut_reg <= readData;
    end else if (state_reg == SEND_RDATA && !csN && dclkFall && bitCnt_reg != 5'h00) begin
      shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dioOut <= 1'b0;
      dioOe <= 1'b0;
    end else begin
      dioOut <= shiftOut_reg[7];
      dioOe <= state_reg == SEND_RDATA && !csN;
    end
  end

  // real-time inputs and interrupt
  logic [7:0] rtChange;
  logic rtEvent;
  logic irqClear;

  assign rtChange = rtInputs ^ rtData_reg;
  assign rtEvent = |(rtChange & ~irqMask_reg);
  assign irqClear = byteDone && state_reg == WAIT_CMD && shiftIn_reg == CMD_RT_DATA_RD_CLR;

  // input pairs arrive already in channel order: A at 2n-2, B at 2n-1
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rtData_reg <= 8'h00;
    end else begin
      rtData_reg <= rtInputs;
    end
  end

  // a change in the clearing cycle keeps the interrupt pending
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqPend_reg <= 1'b0;
    end else if (hwReset) begin
      irqPend_reg <= 1'b0;
    end else if (rtEvent) begin
      irqPend_reg <= 1'b1;
    end else if (irqClear) begin
      irqPend_reg <= 1'b0;
    end
  end

  // active low pin; open drain only drives while pending
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqOut <= 1'b1;
      irqOe <= 1'b0;
    end else begin
      irqOut <= !irqPend_reg;
      irqOe <= chipCfg_reg.irqOpenDrain ? irqPend_reg : 1'b1;
    end
  end

  // chopper: divide rising edges of the 2048 kHz reference by 8 or 7
  logic refPrev_reg;
  logic [2:0] chopCnt_reg;
  logic [2:0] chopLast;

  assign chopLast = chipCfg_reg.chopperDiv7 ? CHOP_LAST_DIV7 : CHOP_LAST_DIV8;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      refPrev_reg <= 1'b0;
      chopCnt_reg <= 3'h0;
      chopperTick <= 1'b0;
    end else begin
      refPrev_reg <= refClk2048;
      chopperTick <= 1'b0;
      if (refClk2048 && !refPrev_reg) begin
        if (chopCnt_reg >= chopLast) begin
          chopCnt_reg <= 3'h0;
          chopperTick <= 1'b1;
        end else begin
          chopCnt_reg <= chopCnt_reg + 3'h1;
        end
      end
    end
  end

  // decoded controls toward the highway, clock and analog logic
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txOnHwyA <= '1;
      txOnHwyB <= '0;
      rxFromHwyB <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        txOnHwyA[i] <= !txCfg[i].hwySel || clkSlot_reg.txBoth;
        txOnHwyB[i] <= txCfg[i].hwySel || clkSlot_reg.txBoth;
        rxFromHwyB[i] <= rxCfg[i].hwySel;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      robbedBitActive <= 1'b0;
      e1MuxAllowed <= 1'b0;
      masterFreqReserved <= 1'b0;
    end else begin
      robbedBitActive <= chanEn_reg.robbedBitEn && muLawSel;
      e1MuxAllowed <= chipCfg_reg.masterClkFromPcm && e1MuxReq;
      masterFreqReserved <= chipCfg_reg.freqBase == FREQ_BASE_RESERVED
        || chipCfg_reg.freqMult == FREQ_MULT_RESERVED;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hwResetEvent <= 1'b0;
    end else begin
      hwResetEvent <= hwReset;
    end
  end

  // launch edge, offsets, signaling and idle mode leave as stored fields
  assign clkSlot = clkSlot_reg;
  assign chipCfg = chipCfg_reg;
  assign chanEn = chanEn_reg;

endmodule

// >>> test/pcm_slot_config_sva.sv
// checker: decode, flag and port-idle relations of the command registers
// bound into pcm_slot_config; sees its ports only
`timescale 1ns/1ps
module pcm_slot_config_sva
  import pcm_slot_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic csN,
  input wire logic dioOe,
  input wire logic muLawSel,
  input wire logic e1MuxReq,
  input wire logic irqOe,
  input wire slot_cfg_type [CHANNELS-1:0] txCfg,
  input wire slot_cfg_type [CHANNELS-1:0] rxCfg,
  input wire logic [CHANNELS-1:0] txOnHwyA,
  input wire logic [CHANNELS-1:0] txOnHwyB,
  input wire logic [CHANNELS-1:0] rxFromHwyB,
  input wire clk_slot_type clkSlot,
  input wire chip_cfg_type chipCfg,
  input wire chan_en_type chanEn,
  input wire logic robbedBitActive,
  input wire logic e1MuxAllowed,
  input wire logic masterFreqReserved,
  input wire logic hwResetEvent
);
  logic [CHANNELS-1:0] txSel;
  logic [CHANNELS-1:0] rxSel;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      txSel[i] = txCfg[i].hwySel;
      rxSel[i] = rxCfg[i].hwySel;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // decoded outputs lag their registers by one cycle, hence the stable guards
  AST_TX_HWY_A:
    assert property ($stable(txCfg) && $stable(clkSlot)
      |-> txOnHwyA == (~txSel | {CHANNELS{clkSlot.txBoth}})) else $error("tx highway A");
  AST_TX_HWY_B:
    assert property ($stable(txCfg) && $stable(clkSlot)
      |-> txOnHwyB == (txSel | {CHANNELS{clkSlot.txBoth}})) else $error("tx highway B");
  AST_RX_HWY_B:
    assert property ($stable(rxCfg) |-> rxFromHwyB == rxSel) else $error("rx highway");
  AST_ROBBED:
    assert property (($stable(chanEn) && $stable(muLawSel)) [*2]
      |-> robbedBitActive == (chanEn.robbedBitEn && muLawSel)) else $error("robbed bit");
  AST_E1_MUX:
    assert property (($stable(chipCfg) && $stable(e1MuxReq)) [*2]
      |-> e1MuxAllowed == (chipCfg.masterClkFromPcm && e1MuxReq)) else $error("e1 mux");
  AST_FREQ_RSVD:
    assert property ($stable(chipCfg) |-> masterFreqReserved == (chipCfg.freqBase
      == FREQ_BASE_RESERVED || chipCfg.freqMult == FREQ_MULT_RESERVED)) else $error("freq");
  AST_IRQ_PUSH_PULL:
    assert property ($stable(chipCfg) && !chipCfg.irqOpenDrain |-> irqOe) else $error("irq oe");
  AST_GLOBAL_HOLD:
    assert property (chanEn.channelCmdEn == 4'h0
      |=> $stable(clkSlot) || chanEn == CHAN_EN_RESET) else $error("clock slot changed");
  AST_HW_RESET:
    assert property ($rose(hwResetEvent) |-> ##[0:1] (chipCfg == CHIP_CFG_RESET
      && chanEn == CHAN_EN_RESET && clkSlot == CLK_SLOT_RESET)) else $error("hw reset");
  AST_DIO_IDLE:
    assert property (csN && $past(csN) |-> !dioOe) else $error("dio driven while idle");
endmodule

bind pcm_slot_config pcm_slot_config_sva #(.CHANNELS(CHANNELS)) sva (
  .clock(clock), .nrst(nrst), .csN(csN), .dioOe(dioOe), .muLawSel(muLawSel),
  .e1MuxReq(e1MuxReq), .irqOe(irqOe), .txCfg(txCfg), .rxCfg(rxCfg), .txOnHwyA(txOnHwyA),
  .txOnHwyB(txOnHwyB), .rxFromHwyB(rxFromHwyB), .clkSlot(clkSlot), .chipCfg(chipCfg),
  .chanEn(chanEn), .robbedBitActive(robbedBitActive), .e1MuxAllowed(e1MuxAllowed),
  .masterFreqReserved(masterFreqReserved), .hwResetEvent(hwResetEvent));

// >>> test/host_mpi_model.sv
// host model: drives the byte-serial command port of the codec
// assumes the device shares clock; lines change at falling edges only
`timescale 1ns/1ps
module host_mpi_model (
  input wire logic clock,
  output logic dclk,
  output logic csN,
  output logic dioIn,
  input wire logic dioOut
);
  initial begin
    dclk = 1'b1;
    csN = 1'b1;
    dioIn = 1'b0;
  end
  // one select period, msb first; dclk rests high so the first fall shifts nothing
  task automatic frame(input logic [15:0] bits, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clock);
    csN = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (3) @(negedge clock);
      dclk = 1'b0;
      dioIn = bits[i];
      repeat (3) @(negedge clock);
      rx = {rx[6:0], dioOut};
      dclk = 1'b1;
    end
    repeat (3) @(negedge clock);
    csN = 1'b1;
    // released line shows no stale copy of the last bit
    dioIn = ~dioIn;
    repeat (3) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    logic [7:0] rx;
    frame({8'h00, cmd}, 8, rx);
    frame({8'h00, data}, 8, rx);
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
    logic [7:0] rx;
    frame({8'h00, cmd}, 8, rx);
    frame(16'h0000, 8, data);
  endtask
endmodule

// >>> test/test_pcm_slot_config.sv
// testbench: host model plus integer register model against the command registers
// assumes a 24-cycle reference clock period, so a chopper period is 8 or 7 of them
`timescale 1ns/1ps
module test_pcm_slot_config;
  import pcm_slot_pkg::*;
  logic clock, nrst, dclk, csN, dioIn, dioOut, dioOe, muLawSel, e1MuxReq, refClk2048;
  logic irqOut, irqOe, robbedBitActive, e1MuxAllowed, masterFreqReserved, chopperTick;
  logic hwResetEvent, pend;
  logic [7:0] rtInputs, rdData, cmd, d;
  logic [3:0] txOnHwyA, txOnHwyB, rxFromHwyB;
  slot_cfg_type [3:0] txCfg, rxCfg;
  clk_slot_type clkSlot;
  chip_cfg_type chipCfg;
  chan_en_type chanEn;
  int fails, compares, seed, gap, oeCnt, mTx[4], mRx[4], mClk, mCfg, mEn, mMask;
  logic [15:0] fixedOps[6] = '{16'h4a00, 16'h44ff, 16'h4a05, 16'h4085, 16'h42c3, 16'h44c7};
  logic [7:0] cmds[7] = '{8'h40, 8'h42, 8'h44, 8'h46, 8'h4a, 8'h6c, 8'h40};
  logic [7:0] rtCmd[2] = '{8'h4d, 8'h4f};

  pcm_slot_config uut (.clock(clock), .nrst(nrst), .dclk(dclk), .csN(csN), .dioIn(dioIn),
    .dioOut(dioOut), .dioOe(dioOe), .rtInputs(rtInputs), .muLawSel(muLawSel),
    .e1MuxReq(e1MuxReq), .refClk2048(refClk2048), .irqOut(irqOut), .irqOe(irqOe),
    .txCfg(txCfg), .rxCfg(rxCfg), .txOnHwyA(txOnHwyA), .txOnHwyB(txOnHwyB),
    .rxFromHwyB(rxFromHwyB), .clkSlot(clkSlot), .chipCfg(chipCfg), .chanEn(chanEn),
    .robbedBitActive(robbedBitActive), .e1MuxAllowed(e1MuxAllowed),
    .masterFreqReserved(masterFreqReserved), .chopperTick(chopperTick),
    .hwResetEvent(hwResetEvent));
  host_mpi_model host (.clock(clock), .dclk(dclk), .csN(csN), .dioIn(dioIn),
    .dioOut(dioOut));
  // cycles of read drive; a read select period is 8 bits of 6 cycles plus 3
  always @(negedge clock) oeCnt += int'(dioOe);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    refClk2048 = 1'b0;
    forever begin
      repeat (12) @(negedge clock);
      refClk2048 = ~refClk2048;
    end
  end

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic void mReset();
    for (int i = 0; i < 4; i++) begin
      mTx[i] = i;
      mRx[i] = i;
    end
    mClk = 8'h00;
    mCfg = 8'h9a;
    mEn = 8'h0f;
    mMask = 8'hff;
    pend = 1'b0;
  endfunction
  function automatic void mWrite(logic [7:0] c, logic [7:0] v);
    for (int i = 0; i < 4; i++) begin
      if (mEn[i] && c == 8'h40) mTx[i] = v;
      if (mEn[i] && c == 8'h42) mRx[i] = v;
    end
    if (c == 8'h44 && mEn[3:0] != 0) mClk = v;
    if (c == 8'h46) mCfg = v;
    if (c == 8'h4a) mEn = v;
    if (c == 8'h6c) mMask = v;
  endfunction
  function automatic int mRead(logic [7:0] c);
    int ch;
    ch = 0;
    while (ch < 3 && !mEn[ch]) ch++;
    case (c)
      8'h41: return mTx[ch];
      8'h43: return mRx[ch];
      8'h45: return mClk;
      8'h47: return mCfg;
      8'h4b: return mEn;
      default: return mMask;
    endcase
  endfunction
  task automatic checkAll();
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] r;
    for (int i = 0; i < 4; i++) begin
      a[i] = !mTx[i][7] || mClk[7];
      b[i] = mTx[i][7] || mClk[7];
      r[i] = mRx[i][7];
      check("txCfg", txCfg[i], 8'(mTx[i]));
      check("rxCfg", rxCfg[i], 8'(mRx[i]));
    end
    check("clkSlot", clkSlot, 8'(mClk));
    check("chipCfg", chipCfg, 8'(mCfg));
    check("chanEn", chanEn, 8'(mEn));
    check("txHwy", {txOnHwyA, txOnHwyB}, {a, b});
    check("rxHwy", {4'h0, rxFromHwyB}, {4'h0, r});
    check("flags", {5'h00, robbedBitActive, e1MuxAllowed, masterFreqReserved},
      {5'h00, mEn[6] && muLawSel, mCfg[4] && e1MuxReq,
      mCfg[1:0] == 3 || mCfg[3:2] == 3});
    check("irq", {6'h00, irqOe, irqOut | mCfg[7]},
      {6'h00, mCfg[7] ? pend : 1'b1, mCfg[7] | !pend});
  endtask
  task automatic tickGap();
    for (int w = 0; w < 3; w++) begin
      gap = 0;
      do begin
        @(negedge clock);
        gap++;
      end while (!chopperTick && gap < 400);
      if (gap >= 400) begin
        fails++;
        finish_test();
      end
    end
  endtask

  initial begin
    seed = 86;
    nrst = 1'b0;
    rtInputs = 8'h00;
    muLawSel = 1'b0;
    e1MuxReq = 1'b0;
    fails = 0;
    compares = 0;
    mReset();
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    checkAll();
    // fixed ops first: all channels off, then a partial enable set
    for (int k = 0; k < 46; k++) begin
      {cmd, d} = (k < 6) ? fixedOps[k] : {cmds[$unsigned($random(seed)) % 7],
        8'($random(seed))};
      if (cmd == 8'h4a && k >= 6) d = d & 8'h6f;
      muLawSel = 1'($random(seed));
      e1MuxReq = 1'($random(seed));
      host.wr(cmd, d);
      mWrite(cmd, d);
      checkAll();
      if (mEn[3:0] != 0 || cmd inside {8'h46, 8'h4a, 8'h6c}) begin
        oeCnt = 0;
        host.rd(cmd | 8'h01, rdData);
        check("read", rdData, 8'(mRead(cmd | 8'h01)));
        check("dioOe", 8'(oeCnt), 8'h33);
      end
    end
    for (int s = 0; s < 2; s++) begin
      host.wr(8'h46, s ? 8'h1a : 8'h9a);
      mWrite(8'h46, s ? 8'h1a : 8'h9a);
      for (int j = 0; j < 2; j++) begin
        host.wr(8'h6c, j ? 8'hfe : 8'hff);
        mWrite(8'h6c, j ? 8'hfe : 8'hff);
        rtInputs = ~rtInputs;
        if (j == 1) pend = 1'b1;
        repeat (4) @(negedge clock);
        checkAll();
        for (int c = 0; c < 2; c++) begin
          host.rd(rtCmd[c], rdData);
          check("rtData", rdData, rtInputs);
          if (rtCmd[c][1]) pend = 1'b0;
          checkAll();
        end
      end
    end
    for (int v = 0; v < 2; v++) begin
      host.wr(8'h46, v ? 8'hda : 8'h9a);
      mWrite(8'h46, v ? 8'hda : 8'h9a);
      tickGap();
      check("chopGap", 8'(gap), v ? 8'ha8 : 8'hc0);
    end
    host.frame(16'h0002, 8, rdData);
    checkAll();
    for (int r = 0; r < 2; r++) begin
      host.wr(8'h46, 8'h1b);
      mWrite(8'h46, 8'h1b);
      host.frame(r ? 16'hffff : 16'h0004, r ? 16 : 8, rdData);
      mReset();
      repeat (3) @(negedge clock);
      checkAll();
    end
    finish_test();
  end
endmodule
